// ### rtl/bps_pkg.sv
// Shared constants and carrier types for the bridge PWM output stage.
// Assumes a classic Wishbone slave port with 32-bit data and byte addresses.
package bps_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [5:0] OFS_PERIOD     = 6'h00;
	localparam logic [5:0] OFS_TIMER_CTRL = 6'h04;
	localparam logic [5:0] OFS_TIMER_STAT = 6'h08;
	localparam logic [5:0] OFS_DUTY_LOW   = 6'h0C;
	localparam logic [5:0] OFS_DUTY_HIGH  = 6'h10;
	localparam logic [5:0] OFS_PWM_CTRL   = 6'h14;
	localparam logic [5:0] OFS_SD_CTRL    = 6'h18;
	localparam logic [5:0] OFS_DEADBAND   = 6'h1C;
	localparam logic [5:0] OFS_PORT_DIR   = 6'h20;
	localparam logic [5:0] OFS_TIMER_CNT  = 6'h24;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_PERIOD   = 8'hFF;
	localparam logic [7:0] RST_PWM_CTRL = 8'h00;
	localparam logic [7:0] RST_SD_CTRL  = 8'h00;
	localparam logic [7:0] RST_DEADBAND = 8'h00;
	localparam logic [3:0] RST_PORT_DIR = 4'hF;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_RUN       = 2;
	localparam int BIT_SD_STATUS = 7;
	localparam logic [1:0] MODE_SINGLE   = 2'h0;
	localparam logic [1:0] MODE_FULL_FWD = 2'h1;
	localparam logic [1:0] MODE_HALF     = 2'h2;
	localparam logic [1:0] MODE_FULL_REV = 2'h3;
	localparam logic [1:0] PWM_SELECT    = 2'h3;

	// ----------------------------------------------------------------
	// Cycle counts
	// ----------------------------------------------------------------
	localparam logic [1:0] INST_LAST = 2'h3; // Four clocks per instruction cycle
	localparam logic [3:0] DIV_P1    = 4'h0;
	localparam logic [3:0] DIV_P4    = 4'h3;
	localparam logic [3:0] DIV_P16   = 4'hF;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [5:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} bps_wb_req_t;

	typedef struct packed {
		logic cmp1;
		logic cmp2;
		logic irq0;
	} bps_sd_src_t;

endpackage : bps_pkg

// ### rtl/bps_sync.sv
// Three-stage synchroniser for the asynchronous shutdown sources.
// Assumes sources may change at any time relative to clock.
`timescale 1ns/1ns
module bps_sync (
	input  wire logic                 clock,
	input  wire logic                 reset,
	input  wire bps_pkg::bps_sd_src_t async_in,
	output bps_pkg::bps_sd_src_t      sync_out
);
	bps_pkg::bps_sd_src_t stage1;
	bps_pkg::bps_sd_src_t stage2;
	bps_pkg::bps_sd_src_t stage3;

	// ----------------------------------------------------------------
	// Chain and agreement
	// ----------------------------------------------------------------
	// Output follows only once the second and third stages agree
	always_ff @(posedge clock) begin
		if (reset) begin
			stage1   <= '0;
			stage2   <= '0;
			stage3   <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
			for (int i = 0; i < 3; i++) begin
				if (stage2[i] == stage3[i]) begin
					sync_out[i] <= stage3[i];
				end
			end
		end
	end

endmodule : bps_sync

// ### rtl/bps_deadband.sv
// Turn-on delay for one half-bridge output.
// Assumes tick is a one-cycle pulse at the instruction rate.
`timescale 1ns/1ns
module bps_deadband (
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       tick,
	input  wire logic       source,
	input  wire logic [7:0] count,
	output logic            active
);
	logic [7:0] remain;

	// ----------------------------------------------------------------
	// Delay counter
	// ----------------------------------------------------------------
	// Falling edge passes at once, rising edge waits count ticks
	always_ff @(posedge clock) begin
		if (reset) begin
			active <= 1'b0;
			remain <= 8'h00;
		end else if (!source) begin
			active <= 1'b0;
			remain <= count;
		end else if (!active) begin
			if (remain == 8'h00) begin
				active <= 1'b1;
			end else if (tick) begin
				remain <= remain - 8'h01;
			end
		end
	end

endmodule : bps_deadband

// ### rtl/bps_top.sv
// Bridge PWM output stage: period timer, duty compare, dead band, polarity
// and auto-shutdown, with registers on a classic Wishbone slave.
// Assumes comparator and interrupt-0 levels arrive asynchronously.
//
// Operation
// - Polarity bits choose active-high or active-low for each output pair.
// - Dead-band count sets instruction cycles between A and B edges.
// - Control holds mode, duty LSBs, polarity/mode; resets to zero.
// - Period from period register; duty from low byte plus control LSBs.
// - Period match starts a cycle and sets the match flag.
// - Auto-shutdown works in every PWM mode.
// - Selected comparator or interrupt-0 source disables outputs.
// - Shutdown drives pins to the programmed pair states.
// - Shutdown gates outputs without waiting for a PWM edge.
// - Shutdown present at cycle start suppresses the whole cycle.
// - Hardware sets shutdown status; only software clears it.
// - Writing one to shutdown status forces shutdown.
// - Source field selects none, comparators, interrupt 0, or combinations.
// - Pair state 00 low, 01 high, 1x tri-state.
// - Dead band delays only the inactive-to-active transition.
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
module bps_top (
	input  wire logic                 clock,
	input  wire logic                 reset,
	input  wire bps_pkg::bps_wb_req_t bus_req,
	output logic [31:0]               bus_dat_r,
	output logic                      bus_ack,
	input  wire bps_pkg::bps_sd_src_t sd_src,
	input  wire logic                 ext_irq0_enable,
	input  wire logic                 cmp1_enable,
	input  wire logic                 cmp2_enable,
	output logic [3:0]                bridge_out,
	output logic [3:0]                bridge_oe
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0]           timer_period_register;
	logic [2:0]           timer_control;
	logic                 timer_match_flag;
	logic [7:0]           duty_low_byte;
	logic [9:0]           duty_latched;
	logic [7:0]           pwm_control;
	logic [7:0]           shutdown_control;
	logic [7:0]           deadband_count;
	logic [3:0]           port_direction_bits;
	logic [7:0]           period_timer;
	logic [1:0]           timer_sub;
	logic [3:0]           prescale_cnt;
	logic [1:0]           inst_cnt;
	logic                 inst_tick;
	logic                 cycle_start;
	logic                 pwm_level;
	logic                 drive_on;
	logic                 db_a;
	logic                 db_b;
	bps_pkg::bps_sd_src_t sd_sync;
	logic                 wr_fire;
	logic                 rd_take;
	logic                 quarter_en;
	logic                 timer_step;
	logic                 period_match;
	logic                 pwm_mode;
	logic                 sd_trigger;
	logic                 sd_force;
	logic                 sd_now;
	logic [3:0]           act;
	logic [3:0]           next_out;
	logic [3:0]           next_oe;
	logic [7:0]           next_rdata;
	logic [1:0]           mode;
	logic [1:0]           pol;
	logic [1:0]           pss_ac;
	logic [1:0]           pss_bd;
	logic [3:0]           sd_oe_mask;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Prescale field to clocks-per-quarter minus one
	function automatic logic [3:0] presc_last(input logic [1:0] field);
		logic [3:0] r;
		r = bps_pkg::DIV_P16;
		if (field == 2'h0) begin
			r = bps_pkg::DIV_P1;
		end else if (field == 2'h1) begin
			r = bps_pkg::DIV_P4;
		end
		return r;
	endfunction : presc_last

	// Write strobe for one register offset
	function automatic logic reg_hit(input logic [5:0] ofs);
		return wr_fire && (bus_req.adr == ofs);
	endfunction : reg_hit

	// ----------------------------------------------------------------
	// Field views
	// ----------------------------------------------------------------
	assign mode     = pwm_control[7:6];
	assign pol      = pwm_control[1:0];
	assign pwm_mode = (pwm_control[3:2] == bps_pkg::PWM_SELECT);
	assign pss_ac   = shutdown_control[3:2];
	assign pss_bd   = shutdown_control[1:0];
	assign sd_oe_mask = ~port_direction_bits
		& ~{pss_bd[1], pss_ac[1], pss_bd[1], pss_ac[1]};

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	// Write lands on the edge where ack is seen high
	assign wr_fire = bus_req.cyc && bus_req.stb && bus_req.we && bus_ack
		&& bus_req.sel[0];
	assign rd_take = bus_req.cyc && bus_req.stb && !bus_ack;

	// Read mux; unmapped offsets read as zero
	always_comb begin
		next_rdata = 8'h00;
		unique case (bus_req.adr)
			bps_pkg::OFS_PERIOD:     next_rdata = timer_period_register;
			bps_pkg::OFS_TIMER_CTRL: next_rdata = {5'h00, timer_control};
			bps_pkg::OFS_TIMER_STAT: next_rdata = {7'h00, timer_match_flag};
			bps_pkg::OFS_DUTY_LOW:   next_rdata = duty_low_byte;
			bps_pkg::OFS_DUTY_HIGH:  next_rdata = duty_latched[9:2];
			bps_pkg::OFS_PWM_CTRL:   next_rdata = pwm_control;
			bps_pkg::OFS_SD_CTRL:    next_rdata = shutdown_control;
			bps_pkg::OFS_DEADBAND:   next_rdata = deadband_count;
			bps_pkg::OFS_PORT_DIR:   next_rdata = {4'h0, port_direction_bits};
			bps_pkg::OFS_TIMER_CNT:  next_rdata = period_timer;
			default:                 next_rdata = 8'h00;
		endcase
	end

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clock) begin
		if (reset) begin
			bus_ack   <= 1'b0;
			bus_dat_r <= 32'h0000_0000;
		end else begin
			bus_ack <= rd_take;
			if (rd_take) begin
				bus_dat_r <= {24'h00_0000, next_rdata};
			end
		end
	end

	// ----------------------------------------------------------------
	// Plain control registers
	// ----------------------------------------------------------------
	// Software-owned configuration
	always_ff @(posedge clock) begin
		if (reset) begin
			timer_period_register <= bps_pkg::RST_PERIOD;
			timer_control         <= 3'h0;
			duty_low_byte         <= 8'h00;
			pwm_control           <= bps_pkg::RST_PWM_CTRL;
			deadband_count        <= bps_pkg::RST_DEADBAND;
			port_direction_bits   <= bps_pkg::RST_PORT_DIR;
		end else begin
			if (reg_hit(bps_pkg::OFS_PERIOD)) begin
				timer_period_register <= bus_req.dat[7:0];
			end
			if (reg_hit(bps_pkg::OFS_TIMER_CTRL)) begin
				timer_control <= bus_req.dat[2:0];
			end
			if (reg_hit(bps_pkg::OFS_DUTY_LOW)) begin
				duty_low_byte <= bus_req.dat[7:0];
			end
			if (reg_hit(bps_pkg::OFS_PWM_CTRL)) begin
				pwm_control <= bus_req.dat[7:0];
			end
			if (reg_hit(bps_pkg::OFS_DEADBAND)) begin
				deadband_count <= bus_req.dat[7:0];
			end
			if (reg_hit(bps_pkg::OFS_PORT_DIR)) begin
				port_direction_bits <= bus_req.dat[3:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Instruction-rate enable
	// ----------------------------------------------------------------
	// Free-running divide by four for the dead-band ticks
	always_ff @(posedge clock) begin
		if (reset) begin
			inst_cnt <= 2'h0;
		end else begin
			inst_cnt <= inst_cnt + 2'h1;
		end
	end
	assign inst_tick = (inst_cnt == bps_pkg::INST_LAST);

	// ----------------------------------------------------------------
	// Period timer
	// ----------------------------------------------------------------
	assign quarter_en   = timer_control[bps_pkg::BIT_RUN]
		&& (prescale_cnt == presc_last(timer_control[1:0]));
	assign timer_step   = quarter_en && (timer_sub == 2'h3);
	assign period_match = timer_step && (period_timer == timer_period_register);

	// Prescaler, quarter count and timer; match restarts the period
	always_ff @(posedge clock) begin
		if (reset) begin
			prescale_cnt <= 4'h0;
			timer_sub    <= 2'h0;
			period_timer <= 8'h00;
			cycle_start  <= 1'b0;
		end else begin
			cycle_start <= period_match;
			if (!timer_control[bps_pkg::BIT_RUN] || quarter_en) begin
				prescale_cnt <= 4'h0;
			end else begin
				prescale_cnt <= prescale_cnt + 4'h1;
			end
			if (quarter_en) begin
				timer_sub <= timer_sub + 2'h1;
			end
			if (period_match) begin
				period_timer <= 8'h00;
			end else if (timer_step) begin
				period_timer <= period_timer + 8'h01;
			end
		end
	end

	// Match flag; a new match wins over a clear in the same cycle
	always_ff @(posedge clock) begin
		if (reset) begin
			timer_match_flag <= 1'b0;
		end else if (period_match) begin
			timer_match_flag <= 1'b1;
		end else if (reg_hit(bps_pkg::OFS_TIMER_STAT) && bus_req.dat[0]) begin
			timer_match_flag <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Duty compare
	// ----------------------------------------------------------------
	// Duty latched at cycle start, compared against ten-bit time
	always_ff @(posedge clock) begin
		if (reset) begin
			duty_latched <= 10'h000;
			pwm_level    <= 1'b0;
		end else begin
			if (period_match) begin
				duty_latched <= {duty_low_byte, pwm_control[5:4]};
			end
			pwm_level <= ({period_timer, timer_sub} < duty_latched);
		end
	end

	// ----------------------------------------------------------------
	// Dead band
	// ----------------------------------------------------------------
	// Turn-on of A and B each delayed, turn-off immediate
	bps_deadband u_db_a (
		.clock  (clock),
		.reset  (reset),
		.tick   (inst_tick),
		.source (pwm_level),
		.count  (deadband_count),
		.active (db_a)
	);

	bps_deadband u_db_b (
		.clock  (clock),
		.reset  (reset),
		.tick   (inst_tick),
		.source (!pwm_level),
		.count  (deadband_count),
		.active (db_b)
	);

	// ----------------------------------------------------------------
	// Shutdown
	// ----------------------------------------------------------------
	bps_sync u_sync (
		.clock    (clock),
		.reset    (reset),
		.async_in (sd_src),
		.sync_out (sd_sync)
	);

	// Source select: bit 4 comparator 1, bit 5 comparator 2, bit 6 irq0
	assign sd_trigger = pwm_mode && (
		(shutdown_control[4] && cmp1_enable && sd_sync.cmp1)
		|| (shutdown_control[5] && cmp2_enable && sd_sync.cmp2)
		|| (shutdown_control[6] && ext_irq0_enable && sd_sync.irq0));
	assign sd_force = reg_hit(bps_pkg::OFS_SD_CTRL)
		&& bus_req.dat[bps_pkg::BIT_SD_STATUS];
	assign sd_now = sd_trigger || sd_force
		|| shutdown_control[bps_pkg::BIT_SD_STATUS];

	// Status bit: hardware or a written one sets, written zero clears
	always_ff @(posedge clock) begin
		if (reset) begin
			shutdown_control <= bps_pkg::RST_SD_CTRL;
		end else begin
			if (reg_hit(bps_pkg::OFS_SD_CTRL)) begin
				shutdown_control[6:0] <= bus_req.dat[6:0];
			end
			if (sd_trigger || sd_force) begin
				shutdown_control[bps_pkg::BIT_SD_STATUS] <= 1'b1;
			end else if (reg_hit(bps_pkg::OFS_SD_CTRL)) begin
				shutdown_control[bps_pkg::BIT_SD_STATUS] <= 1'b0;
			end
		end
	end

	// Drive permit: dropped by shutdown, regained only at a clean cycle start
	always_ff @(posedge clock) begin
		if (reset) begin
			drive_on <= 1'b0;
		end else if (sd_now) begin
			drive_on <= 1'b0;
		end else if (cycle_start) begin
			drive_on <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Output steering
	// ----------------------------------------------------------------
	// Logical active levels per mode, index 0..3 is A..D
	always_comb begin
		act = 4'h0;
		unique case (mode)
			bps_pkg::MODE_SINGLE:   act = {3'h0, pwm_level};
			bps_pkg::MODE_FULL_FWD: act = {pwm_level, 2'h0, 1'b1};
			bps_pkg::MODE_HALF:     act = {2'h0, db_b, db_a};
			bps_pkg::MODE_FULL_REV: act = {1'b0, 1'b1, pwm_level, 1'b0};
		endcase
	end

	// Polarity, shutdown states and pin direction
	always_comb begin
		next_out = 4'h0;
		next_oe  = 4'h0;
		if (pwm_mode && (sd_now || !drive_on)) begin
			next_out = {pss_bd[0], pss_ac[0], pss_bd[0], pss_ac[0]};
			next_oe  = sd_oe_mask;
		end else if (pwm_mode) begin
			next_out = act ^ {pol[0], pol[1], pol[0], pol[1]};
			next_oe  = ~port_direction_bits;
		end
	end

	// Pin registers
	always_ff @(posedge clock) begin
		if (reset) begin
			bridge_out <= 4'h0;
			bridge_oe  <= 4'h0;
		end else begin
			bridge_out <= next_out;
			bridge_oe  <= next_oe;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_ctrl_reset_zero: assert property (
		$past(reset) |-> (pwm_control == 8'h00) && (shutdown_control == 8'h00))
		else $error("control registers not zero after reset");

	a_pol_drive_a: assert property (
		pwm_mode && !sd_now && drive_on && $stable(pwm_control)
		|=> bridge_out[0] == ($past(act[0]) ^ $past(pol[1])))
		else $error("output A polarity wrong");

	a_db_rise_held: assert property (
		(mode == bps_pkg::MODE_HALF) && (deadband_count > 8'h01) && $rose(pwm_level)
		|=> !db_a [*4])
		else $error("dead band did not delay turn-on of A");

	a_db_fall_fast: assert property (
		$fell(pwm_level) |=> !db_a)
		else $error("turn-off of A was delayed");

	a_match_flag_set: assert property (
		cycle_start |-> timer_match_flag)
		else $error("cycle start without match flag");

	a_sd_event_set: assert property (
		sd_trigger |=> shutdown_control[bps_pkg::BIT_SD_STATUS] ##0 !drive_on)
		else $error("shutdown source did not set status");

	a_sd_status_hold: assert property (
		shutdown_control[bps_pkg::BIT_SD_STATUS]
		&& !(wr_fire && (bus_req.adr == bps_pkg::OFS_SD_CTRL))
		|=> shutdown_control[bps_pkg::BIT_SD_STATUS])
		else $error("shutdown status cleared without software");

	a_sd_force_write: assert property (
		sd_force |=> shutdown_control[bps_pkg::BIT_SD_STATUS]
			&& (bridge_oe == $past(sd_oe_mask)))
		else $error("written one did not force shutdown");

	a_sd_pin_state: assert property (
		$past(pwm_mode) && $past(sd_now) && $stable(shutdown_control[3:0]) && !pss_ac[1]
		|-> bridge_out[0] == pss_ac[0])
		else $error("pin A not at shutdown level");

	a_resume_at_cycle: assert property (
		$fell(shutdown_control[bps_pkg::BIT_SD_STATUS]) && !cycle_start && !drive_on
		|=> !drive_on)
		else $error("drive resumed in mid-cycle");

endmodule : bps_top

// ### bench/bps_switch_model.sv
// Power switch driver model that sits on the four bridge pins.
// Assumes undriven pins are held low by external pull-downs.
`timescale 1ns/1ns
module bps_switch_model (
	input  wire logic       clock,
	input  wire logic [3:0] bridge_out,
	input  wire logic [3:0] bridge_oe,
	output logic [3:0]      pin,
	output int              n_overlap,
	output int              n_rise_a,
	output int              n_rise_b
);
	logic [3:0] pin_q;
	// Released pins settle at the pull-down level
	assign pin = bridge_oe & bridge_out;
	// Counters start clear
	initial begin
		n_overlap = 0;
		n_rise_a = 0;
		n_rise_b = 0;
		pin_q = 4'h0;
	end
	// Count turn-ons and cycles where both switches of the leg conduct
	always @(posedge clock) begin
		pin_q <= pin;
		if (pin[0] === 1'b1 && pin[1] === 1'b1) n_overlap <= n_overlap + 1;
		if (pin[0] === 1'b1 && pin_q[0] === 1'b0) n_rise_a <= n_rise_a + 1;
		if (pin[1] === 1'b1 && pin_q[1] === 1'b0) n_rise_b <= n_rise_b + 1;
	end
endmodule : bps_switch_model

// ### bench/tb_bps_top.sv
// Self-checking bench for the bridge PWM output stage.
// Assumes a classic Wishbone master and the switch model on the pins.
`timescale 1ns/1ns
module tb_bps_top;
	logic                 clock = 1'b0;
	logic                 reset = 1'b1;
	bps_pkg::bps_wb_req_t bus_req = '0;
	bps_pkg::bps_sd_src_t sd_src = '0;
	logic                 irq_en = 1'b0;
	logic                 c1_en = 1'b0;
	logic                 c2_en = 1'b0;
	logic [31:0]          bus_dat_r;
	logic                 bus_ack;
	logic [3:0]           bridge_out;
	logic [3:0]           bridge_oe;
	logic [3:0]           pin;
	int                   n_ov, n_ra, n_rb, n_mismatch = 0, total_checks = 0;
	logic [7:0]           q;
	// ----------------------------------------------------------------
	// Clock, design and far side
	// ----------------------------------------------------------------
	always #2 clock = ~clock;
	bps_top bps_top_inst (.clock(clock), .reset(reset), .bus_req(bus_req),
		.bus_dat_r(bus_dat_r), .bus_ack(bus_ack), .sd_src(sd_src),
		.ext_irq0_enable(irq_en), .cmp1_enable(c1_en), .cmp2_enable(c2_en),
		.bridge_out(bridge_out), .bridge_oe(bridge_oe));
	bps_switch_model bps_switch_model_inst (.clock(clock), .bridge_out(bridge_out),
		.bridge_oe(bridge_oe), .pin(pin), .n_overlap(n_ov), .n_rise_a(n_ra),
		.n_rise_b(n_rb));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : final_report
	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	// One classic cycle; held until ack is sampled high
	task wb(input logic we, input logic [5:0] a, input logic [7:0] d);
		int i;
		@(posedge clock);
		bus_req <= '{1'b1, 1'b1, we, a, 4'hF, {24'h000000, d}};
		for (i = 0; i < 20; i++) begin
			@(posedge clock);
			if (bus_ack === 1'b1) break;
		end
		if (i == 20) begin
			n_mismatch++;
			final_report();
		end
		q = bus_dat_r[7:0];
		bus_req <= '0;
	endtask : wb
	task idle(input int n);
		repeat (n) @(posedge clock);
	endtask : idle
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_reset;
		wb(1'b0, bps_pkg::OFS_PWM_CTRL, 8'h00);
		check("pwm_control", 32'h00, q);
		wb(1'b0, bps_pkg::OFS_SD_CTRL, 8'h00);
		check("shutdown_control", 32'h00, q);
		wb(1'b0, bps_pkg::OFS_DEADBAND, 8'h00);
		check("deadband_count", 32'h00, q);
		wb(1'b0, bps_pkg::OFS_PERIOD, 8'h00);
		check("period", 32'hFF, q);
		$display("test reset done");
	endtask : t_reset
	task t_half;
		int i;
		int ov0, ra0, rb0;
		wb(1'b1, bps_pkg::OFS_PORT_DIR, 8'h0F);
		wb(1'b1, bps_pkg::OFS_PERIOD, 8'h07);
		wb(1'b1, bps_pkg::OFS_DUTY_LOW, 8'h04);
		wb(1'b1, bps_pkg::OFS_PWM_CTRL, 8'h8C);
		wb(1'b1, bps_pkg::OFS_DEADBAND, 8'h02);
		wb(1'b1, bps_pkg::OFS_TIMER_STAT, 8'h01);
		wb(1'b1, bps_pkg::OFS_TIMER_CTRL, 8'h04);
		for (i = 0; i < 40; i++) begin
			wb(1'b0, bps_pkg::OFS_TIMER_STAT, 8'h00);
			if (q[0] === 1'b1) break;
		end
		check("match flag", 32'h1, q[0]);
		wb(1'b1, bps_pkg::OFS_PORT_DIR, 8'h00);
		idle(8);
		ov0 = n_ov;
		ra0 = n_ra;
		rb0 = n_rb;
		idle(100);
		check("leg overlap", 32'h0, n_ov - ov0);
		check("a turned on", 32'h1, n_ra > ra0);
		check("b turned on", 32'h1, n_rb > rb0);
		$display("test half bridge done");
	endtask : t_half
	task t_shutdown;
		c1_en <= 1'b1;
		wb(1'b1, bps_pkg::OFS_SD_CTRL, 8'h16);
		sd_src <= '{1'b1, 1'b0, 1'b0};
		idle(10);
		check("pins", 32'hB, {bridge_oe, bridge_out[0]});
		wb(1'b0, bps_pkg::OFS_SD_CTRL, 8'h00);
		check("status", 32'h96, q);
		wb(1'b1, bps_pkg::OFS_SD_CTRL, 8'h16);
		wb(1'b0, bps_pkg::OFS_SD_CTRL, 8'h00);
		check("status held", 32'h96, q);
		sd_src <= '0;
		idle(10);
		wb(1'b1, bps_pkg::OFS_SD_CTRL, 8'h16);
		wb(1'b0, bps_pkg::OFS_SD_CTRL, 8'h00);
		check("status cleared", 32'h16, q);
		idle(40);
		check("b driven again", 32'h1, bridge_oe[1]);
		$display("test shutdown done");
	endtask : t_shutdown
	task t_decode;
		logic [2:0] m;
		irq_en <= 1'b1;
		c2_en <= 1'b1;
		for (int c = 0; c < 8; c++) begin
			m = 3'h1 << (c % 3);
			wb(1'b1, bps_pkg::OFS_SD_CTRL, {1'b0, c[2:0], 4'h0});
			sd_src <= '{m[0], m[1], m[2]};
			idle(10);
			wb(1'b0, bps_pkg::OFS_SD_CTRL, 8'h00);
			check("source decode", 32'h1, q[7] === |(c[2:0] & m));
			sd_src <= '0;
			idle(10);
			wb(1'b1, bps_pkg::OFS_SD_CTRL, 8'h00);
		end
		$display("test source decode done");
	endtask : t_decode
	task t_force;
		wb(1'b1, bps_pkg::OFS_SD_CTRL, 8'h80);
		idle(2);
		check("forced pins", 32'h2, {bridge_oe[0], bridge_out[0]});
		wb(1'b0, bps_pkg::OFS_SD_CTRL, 8'h00);
		check("forced status", 32'h80, q);
		wb(1'b1, bps_pkg::OFS_SD_CTRL, 8'h00);
		$display("test force done");
	endtask : t_force
	task t_polarity;
		wb(1'b1, bps_pkg::OFS_PORT_DIR, 8'h0F);
		wb(1'b1, bps_pkg::OFS_DUTY_LOW, 8'h00);
		wb(1'b1, bps_pkg::OFS_PWM_CTRL, 8'h0F);
		wb(1'b1, bps_pkg::OFS_PORT_DIR, 8'h00);
		idle(40);
		check("a low active idle", 32'h3, {bridge_oe[0], bridge_out[0]});
		wb(1'b1, bps_pkg::OFS_PORT_DIR, 8'h0F);
		wb(1'b1, bps_pkg::OFS_PWM_CTRL, 8'h0C);
		wb(1'b1, bps_pkg::OFS_PORT_DIR, 8'h00);
		idle(40);
		check("a high active idle", 32'h2, {bridge_oe[0], bridge_out[0]});
		wb(1'b1, bps_pkg::OFS_PWM_CTRL, 8'h4C);
		idle(40);
		check("full forward a", 32'h3, {bridge_oe[0], bridge_out[0]});
		wb(1'b1, bps_pkg::OFS_PWM_CTRL, 8'hCC);
		idle(40);
		check("full reverse c a", 32'h2, {bridge_out[2], bridge_out[0]});
		$display("test polarity done");
	endtask : t_polarity
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		idle(3);
		reset <= 1'b0;
		t_reset();
		t_half();
		t_shutdown();
		t_decode();
		t_force();
		t_polarity();
		final_report();
	end
endmodule : tb_bps_top
